// *** verilog/timer8_pkg.sv ***
// Purpose: Shared constants and types of the 8-bit timer waveform block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are chosen for this block.
package timer8_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_WAVE_OUT    = 8'h00;
  localparam logic [7:0] ADDR_CLK_FORCE   = 8'h04;
  localparam logic [7:0] ADDR_COUNT       = 8'h08;
  localparam logic [7:0] ADDR_CMP_A       = 8'h0C;
  localparam logic [7:0] ADDR_CMP_B       = 8'h10;
  localparam logic [7:0] ADDR_FLAGS       = 8'h14;
  localparam logic [7:0] ADDR_PIN_CTRL    = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int A_MODE_LSB   = 6;
  localparam int B_MODE_LSB   = 4;
  localparam int WAVE_LO_LSB  = 0;
  localparam int FORCE_A_BIT  = 7;
  localparam int FORCE_B_BIT  = 6;
  localparam int WAVE2_BIT    = 3;
  localparam int CLK_SEL_LSB  = 0;
  localparam int OVF_BIT      = 0;
  localparam int DIR_A_BIT    = 0;
  localparam int DIR_B_BIT    = 1;
  localparam int FLAG_A_BIT   = 1;
  localparam int FLAG_B_BIT   = 2;

  // ==========================================================================
  // Reset values and constants
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  localparam logic [7:0] COUNT_BOT   = 8'h00;
  localparam logic [7:0] WAVE_OUT_RD = 8'hF3;
  localparam logic [7:0] CLK_FRC_RD  = 8'h0F;
  localparam int PRESC_W = 10;

  // ==========================================================================
  // Types
  typedef enum logic [2:0]
  {
    WM_NORMAL   = 3'd0,
    WM_PC_FF    = 3'd1,
    WM_CTC      = 3'd2,
    WM_FAST_FF  = 3'd3,
    WM_RSV4     = 3'd4,
    WM_PC_A     = 3'd5,
    WM_RSV6     = 3'd6,
    WM_FAST_A   = 3'd7
  } wave_mode_t;

  typedef enum logic [2:0]
  {
    CS_STOP = 3'd0,
    CS_DIV1 = 3'd1,
    CS_DIV8 = 3'd2,
    CS_DIV64 = 3'd3,
    CS_DIV256 = 3'd4,
    CS_DIV1024 = 3'd5,
    CS_EXT_FALL = 3'd6,
    CS_EXT_RISE = 3'd7
  } clk_sel_t;

  typedef struct packed
  {
    logic       pin;
    logic       oe;
  } cmp_pin_t;

endpackage

// *** verilog/timer8_waveform_control.sv ***
// Purpose: 8-bit timer with two compare channels, modes and clock select.
// Assumes: APB slave on pclk; ext_count_pin is asynchronous.
// Notes:   Prescaler is local and free running.
//
// What this block does
// - Phase-correct A: 10 clear up, set down.
// - PWM A mode 01 toggles only if bit2.
// - Compare equal TOP: act at TOP instead.
// - Nonzero B mode overrides port function.
// - B driver needs direction bit set.
// - Non-PWM B: off, toggle, clear, set.
// - Fast PWM B: 10 clear/set TOP, 11 opposite.
// - Phase-correct B: 10 clear up, set down.
// - Mode bits select sequence, TOP, waveform.
// - Modes 0-3 TOP, buffering and overflow point.
// - Mode 5 dual slope, 7 fast, 4/6 reserved.
// - Force strobe acts only in non-PWM modes.
// - Force sets no flag, no clear; reads zero.
// - Clock select stop, direct, prescaler taps.
// - Select 110 falling, 111 rising ext edge.
// - External pin counts even as output.
// - Reserved control bits read as zero.
// - Phase-correct counts up then down.
// - Overflow flag cleared by ack or write one.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

module timer8_waveform_control
  import timer8_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Pins and acknowledge
  input  wire logic                  ext_count_pin,
  input  wire logic                  ovf_ack,
  output timer8_pkg::cmp_pin_t       cmp_a_pin,
  output timer8_pkg::cmp_pin_t       cmp_b_pin,
  output logic                       overflow_flag
);
  import timer8_pkg::*;

  // ==========================================================================
  // Registers
  logic [1:0]  cmp_a_out_mode;
  logic [1:0]  cmp_b_out_mode;
  logic [2:0]  wave_mode;
  logic [2:0]  clk_sel;
  logic [7:0]  count_value;
  logic [7:0]  cmp_a_value;
  logic [7:0]  cmp_b_value;
  logic [7:0]  cmp_a_buf;
  logic [7:0]  cmp_b_buf;
  logic [1:0]  port_dir;
  logic        flag_a;
  logic        flag_b;
  logic        count_down;
  logic        wave_a;
  logic        wave_b;
  logic [PRESC_W-1:0] presc;
  logic [2:0]  ext_sync;
  logic        apb_wr;
  logic        apb_rd;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == WM_PC_FF) || (m == WM_FAST_FF) || (m == WM_PC_A) ||
             (m == WM_FAST_A);
  endfunction

  function automatic logic is_pc(input logic [2:0] m);
    is_pc = (m == WM_PC_FF) || (m == WM_PC_A);
  endfunction

  // Returns the new pin level for a non-PWM match.
  function automatic logic match_act(input logic [1:0] md, input logic cur);
    case (md)
      2'b01:   match_act = !cur;
      2'b10:   match_act = 1'b0;
      2'b11:   match_act = 1'b1;
      default: match_act = cur;
    endcase
  endfunction

  // ==========================================================================
  // Decode of mode, TOP and count enable
  wave_mode_t  mode;
  logic        pwm;
  logic        pc;
  logic [7:0]  top;
  logic        tick;
  logic        ext_fall;
  logic        ext_rise;

  assign mode = wave_mode_t'(wave_mode);
  assign pwm  = is_pwm(wave_mode);
  assign pc   = is_pc(wave_mode);
  always_comb
  begin
    case (mode)
      WM_CTC, WM_PC_A, WM_FAST_A: top = cmp_a_value;
      default:                    top = COUNT_MAX;
    endcase
  end

  // The pin edge is only seen after two flops, so it lags 2 to 3 clocks.
  assign ext_fall = ext_sync[2] && !ext_sync[1];
  assign ext_rise = !ext_sync[2] && ext_sync[1];

  always_comb
  begin
    case (clk_sel_t'(clk_sel))
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (presc[2:0] == 3'h7);
      CS_DIV64:    tick = (presc[5:0] == 6'h3F);
      CS_DIV256:   tick = (presc[7:0] == 8'hFF);
      CS_DIV1024:  tick = (presc == {PRESC_W{1'b1}});
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
      default:     tick = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc <= '0;
    else
      presc <= presc + 1'b1;
  end

  // The pin is sampled regardless of its port direction.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_sync <= 3'b000;
    else
      ext_sync <= {ext_sync[1:0], ext_count_pin};
  end

  // ==========================================================================
  // Control registers
  logic force_a;
  logic force_b;
  assign force_a = apb_wr && (paddr == ADDR_CLK_FORCE) &&
                   pwdata[FORCE_A_BIT] && !pwm;
  assign force_b = apb_wr && (paddr == ADDR_CLK_FORCE) &&
                   pwdata[FORCE_B_BIT] && !pwm;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_a_out_mode <= 2'b00;
      cmp_b_out_mode <= 2'b00;
      wave_mode      <= 3'b000;
      clk_sel        <= 3'b000;
      port_dir       <= 2'b00;
    end
    else if (apb_wr)
    begin
      if (paddr == ADDR_WAVE_OUT)
      begin
        cmp_a_out_mode <= pwdata[A_MODE_LSB +: 2];
        cmp_b_out_mode <= pwdata[B_MODE_LSB +: 2];
        wave_mode[1:0] <= pwdata[WAVE_LO_LSB +: 2];
      end
      if (paddr == ADDR_CLK_FORCE)
      begin
        wave_mode[2] <= pwdata[WAVE2_BIT];
        clk_sel      <= pwdata[CLK_SEL_LSB +: 3];
      end
      if (paddr == ADDR_PIN_CTRL)
        port_dir <= pwdata[1:0];
    end
  end

  // Compare values: written to a buffer, taken at TOP in PWM modes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_a_buf <= 8'h00;
      cmp_b_buf <= 8'h00;
    end
    else if (apb_wr && paddr == ADDR_CMP_A)
      cmp_a_buf <= pwdata[7:0];
    else if (apb_wr && paddr == ADDR_CMP_B)
      cmp_b_buf <= pwdata[7:0];
  end

  logic at_top;
  assign at_top = tick && (count_value == top);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_a_value <= 8'h00;
      cmp_b_value <= 8'h00;
    end
    else if (!pwm || at_top)
    begin
      cmp_a_value <= cmp_a_buf;
      cmp_b_value <= cmp_b_buf;
    end
  end

  // ==========================================================================
  // Counter
  logic match_a;
  logic match_b;
  assign match_a = tick && (count_value == cmp_a_value);
  assign match_b = tick && (count_value == cmp_b_value);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_value <= COUNT_BOT;
      count_down  <= 1'b0;
    end
    else if (apb_wr && paddr == ADDR_COUNT)
      count_value <= pwdata[7:0];
    else if (tick)
    begin
      if (pc)
      begin
        if (count_value == top || (count_down && count_value != COUNT_BOT))
        begin
          count_down  <= (count_value != COUNT_BOT);
          count_value <= count_value - 1'b1;
        end
        else
        begin
          count_down  <= 1'b0;
          count_value <= count_value + 1'b1;
        end
      end
      else if (count_value == top)
        count_value <= COUNT_BOT;
      else
        count_value <= count_value + 1'b1;
    end
  end

  // ==========================================================================
  // Flags
  logic ovf_set;
  always_comb
  begin
    case (mode)
      WM_PC_FF, WM_PC_A: ovf_set = tick && count_value == COUNT_BOT &&
                                   count_down;
      WM_FAST_A:         ovf_set = at_top;
      WM_RSV4, WM_RSV6:  ovf_set = 1'b0;
      default:           ovf_set = tick && count_value == COUNT_MAX;
    endcase
  end

  // Set wins over clear so an overflow in the clearing cycle is kept.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overflow_flag <= 1'b0;
      flag_a        <= 1'b0;
      flag_b        <= 1'b0;
    end
    else
    begin
      if (ovf_set)
        overflow_flag <= 1'b1;
      else if (ovf_ack || (apb_wr && paddr == ADDR_FLAGS &&
                           pwdata[OVF_BIT]))
        overflow_flag <= 1'b0;
      // Force strobes never reach these flags.
      if (match_a)
        flag_a <= 1'b1;
      else if (apb_wr && paddr == ADDR_FLAGS && pwdata[FLAG_A_BIT])
        flag_a <= 1'b0;
      if (match_b)
        flag_b <= 1'b1;
      else if (apb_wr && paddr == ADDR_FLAGS && pwdata[FLAG_B_BIT])
        flag_b <= 1'b0;
    end
  end

  // ==========================================================================
  // Waveform generators
  logic top_a;
  logic top_b;
  // A compare value equal to TOP moves the action to TOP itself.
  assign top_a = (cmp_a_value == top) && cmp_a_out_mode[1];
  assign top_b = (cmp_b_value == top) && cmp_b_out_mode[1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wave_a <= 1'b0;
    else if (!pwm)
    begin
      if (match_a || force_a)
        wave_a <= match_act(cmp_a_out_mode, wave_a);
    end
    else if (cmp_a_out_mode == 2'b01)
    begin
      if (match_a && wave_mode[2])
        wave_a <= !wave_a;
    end
    else if (pc)
    begin
      if (top_a ? at_top : match_a)
        wave_a <= cmp_a_out_mode[0] ^ count_down ^ top_a;
    end
    else if (at_top && top_a)
      wave_a <= cmp_a_out_mode[0];
    else if (at_top)
      wave_a <= !cmp_a_out_mode[0];
    else if (match_a)
      wave_a <= cmp_a_out_mode[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wave_b <= 1'b0;
    else if (!pwm)
    begin
      if (match_b || force_b)
        wave_b <= match_act(cmp_b_out_mode, wave_b);
    end
    else if (!cmp_b_out_mode[1])
      wave_b <= wave_b;
    else if (pc)
    begin
      if (top_b ? at_top : match_b)
        wave_b <= cmp_b_out_mode[0] ^ count_down ^ top_b;
    end
    else if (at_top && top_b)
      wave_b <= cmp_b_out_mode[0];
    else if (at_top)
      wave_b <= !cmp_b_out_mode[0];
    else if (match_b)
      wave_b <= cmp_b_out_mode[0];
  end

  // ==========================================================================
  // Pin outputs
  logic a_conn;
  assign a_conn = (cmp_a_out_mode != 2'b00) &&
                  !(pwm && cmp_a_out_mode == 2'b01 && !wave_mode[2]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_a_pin <= '0;
      cmp_b_pin <= '0;
    end
    else
    begin
      cmp_a_pin.pin <= wave_a;
      cmp_a_pin.oe  <= a_conn && port_dir[DIR_A_BIT];
      cmp_b_pin.pin <= wave_b;
      cmp_b_pin.oe  <= (cmp_b_out_mode != 2'b00) &&
                       port_dir[DIR_B_BIT];
    end
  end

  // ==========================================================================
  // APB read path: one wait-free access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != ADDR_WAVE_OUT &&
                 paddr != ADDR_CLK_FORCE && paddr != ADDR_COUNT &&
                 paddr != ADDR_CMP_A && paddr != ADDR_CMP_B &&
                 paddr != ADDR_FLAGS && paddr != ADDR_PIN_CTRL;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
        case (paddr)
          ADDR_WAVE_OUT:  prdata[7:0] <= WAVE_OUT_RD &
            {cmp_a_out_mode, cmp_b_out_mode, 2'b00, wave_mode[1:0]};
          ADDR_CLK_FORCE: prdata[7:0] <= CLK_FRC_RD &
            {4'h0, wave_mode[2], clk_sel};
          ADDR_COUNT:     prdata[7:0] <= count_value;
          ADDR_CMP_A:     prdata[7:0] <= cmp_a_buf;
          ADDR_CMP_B:     prdata[7:0] <= cmp_b_buf;
          ADDR_FLAGS:     prdata[7:0] <= {5'h00, flag_b, flag_a, overflow_flag};
          ADDR_PIN_CTRL:  prdata[7:0] <= {6'h00, port_dir};
          default:        prdata[7:0] <= 8'h00;
        endcase
    end
  end

endmodule

`default_nettype wire

// *** sim/timer8_waveform_control_monitor.sv ***
// Purpose: Port assertions for the 8-bit timer waveform block.
// Assumes: Zero-wait APB slave, one register per aligned word.
// Notes:   Bound to every instance of the block.
`timescale 1ns/100ps
`default_nettype none

module timer8_waveform_control_monitor
  import timer8_pkg::*;
(
  // Clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  // Pins
  input wire logic             ext_count_pin,
  input wire logic             ovf_ack,
  input wire timer8_pkg::cmp_pin_t cmp_a_pin,
  input wire timer8_pkg::cmp_pin_t cmp_b_pin,
  input wire logic             overflow_flag
);
  import timer8_pkg::*;

  // ==========================================================================
  // Helpers
  logic setup_ph;
  logic ovf_w1c;
  logic rd_ok;
  assign setup_ph = psel && !penable;
  assign ovf_w1c  = psel && penable && pwrite && paddr == ADDR_FLAGS
                    && pwdata[OVF_BIT];
  assign rd_ok    = pready && !pwrite && !pslverr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Checks
  ready_after_setup_a: assert property (setup_ph |=> pready)
    else $error("pready missing in access phase");
  ready_cause_a: assert property (pready |-> psel && penable && $past(setup_ph))
    else $error("pready without a transfer");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero while idle");
  map_err_a: assert property (pready |->
      pslverr == (paddr > ADDR_PIN_CTRL || paddr[1:0] != 2'b00))
    else $error("pslverr does not match address map");
  wave_resv_a: assert property (rd_ok && paddr == ADDR_WAVE_OUT |->
      prdata[3:2] == 2'b00 && prdata[31:8] == 24'h00_0000)
    else $error("reserved wave bits read nonzero");
  force_rd_zero_a: assert property (rd_ok && paddr == ADDR_CLK_FORCE |->
      prdata[7:4] == 4'h0 && prdata[31:8] == 24'h00_0000)
    else $error("force or reserved bits read nonzero");
  ovf_clear_a: assert property ($fell(overflow_flag) |->
      $past(ovf_ack) || $past(ovf_w1c))
    else $error("overflow flag fell without clear");
  reset_pins_a: assert property ($rose(presetn) |->
      cmp_a_pin == 2'b00 && cmp_b_pin == 2'b00 && !overflow_flag)
    else $error("outputs not idle after reset");

endmodule

bind timer8_waveform_control timer8_waveform_control_monitor i_mon
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
  .ovf_ack(ovf_ack), .cmp_a_pin(cmp_a_pin), .cmp_b_pin(cmp_b_pin),
  .overflow_flag(overflow_flag)
);

`default_nettype wire

// *** sim/ext_count_model.sv ***
// Purpose: External count source driving the timer count pin.
// Assumes: Pin levels change just after a rising pclk edge.
// Notes:   High levels are held four clocks and low levels five, above the sync delay.
`timescale 1ns/100ps
`default_nettype none

module ext_count_model
(
  // Clock
  input wire logic pclk,
  // Count pin
  output logic     ext_count_pin
);
  initial ext_count_pin = 1'b0;

  // ==========================================================================
  // Pulse source
  // Long levels keep every edge visible to the synchroniser.
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge pclk) ext_count_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule

`default_nettype wire

// *** sim/timer8_waveform_control_tb.sv ***
// Purpose: Self-checking bench for the 8-bit timer waveform block.
// Assumes: Zero-wait APB slave, registers in bits 7:0.
// Notes:   Pin checks wait two clocks after the launching write.
`timescale 1ns/100ps
`default_nettype none

module timer8_waveform_control_tb;
  import timer8_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, ovf_ack;
  logic        pready, pslverr, overflow_flag, ext_count_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  cmp_pin_t    cmp_a_pin, cmp_b_pin;
  logic        rerr;
  int          miscompares, n_tests;
  logic [1:0]  modes [4] = '{2'd1, 2'd1, 2'd3, 2'd2};
  logic        pins  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  timer8_waveform_control i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
    .ovf_ack(ovf_ack), .cmp_a_pin(cmp_a_pin), .cmp_b_pin(cmp_b_pin),
    .overflow_flag(overflow_flag)
  );
  ext_count_model i_ext (.pclk(pclk), .ext_count_pin(ext_count_pin));

  always #5 pclk = ~pclk;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      miscompares++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial
  begin
    #400000;
    miscompares++;
    results();
  end

  // ==========================================================================
  // Tests
  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000; ovf_ack = 1'b0;
    miscompares = 0; n_tests = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_WAVE_OUT);  chk(rdat, 32'h0000_0000);
    rd(ADDR_CLK_FORCE); chk(rdat, 32'h0000_0000);
    chk({cmp_a_pin, cmp_b_pin}, 32'h0000_0000);
    wr(ADDR_WAVE_OUT, 8'hFF);
    rd(ADDR_WAVE_OUT);  chk(rdat, 32'h0000_00F3);
    wr(ADDR_CLK_FORCE, 8'hF8);
    rd(ADDR_CLK_FORCE); chk(rdat, 32'h0000_0008);
    wr(ADDR_CLK_FORCE, 8'h00);
    rd(8'h40); chk({31'h0000_0000, rerr}, 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
    // External edges count even though nothing marks the pin as input.
    wr(ADDR_WAVE_OUT, 8'h00);
    wr(ADDR_CLK_FORCE, 8'h07);
    wr(ADDR_COUNT, 8'h00);
    i_ext.pulses(3);
    rd(ADDR_COUNT); chk(rdat, 32'h0000_0003);
    wr(ADDR_CLK_FORCE, 8'h06);
    i_ext.pulses(2);
    rd(ADDR_COUNT); chk(rdat, 32'h0000_0005);
    wr(ADDR_CLK_FORCE, 8'h00);
    i_ext.pulses(2);
    rd(ADDR_COUNT); chk(rdat, 32'h0000_0005);
    // Overflow at MAX in normal mode, cleared by ack then by write one.
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_COUNT, 8'hF0);
      wr(ADDR_CLK_FORCE, 8'h01);
      repeat (30) @(posedge pclk);
      wr(ADDR_CLK_FORCE, 8'h00);
      chk(overflow_flag, 1'b1);
      if (i == 0)
      begin
        ovf_ack <= 1'b1;
        @(posedge pclk);
        ovf_ack <= 1'b0;
      end
      else
        wr(ADDR_FLAGS, 8'h01);
      repeat (2) @(posedge pclk);
      chk(overflow_flag, 1'b0);
    end
    // Forced matches in normal mode walk the toggle, set and clear non-PWM actions.
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_PIN_CTRL, 8'h03);
    wr(ADDR_CMP_B, 8'h80);
    repeat (2) @(posedge pclk);
    chk(cmp_b_pin.oe, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_WAVE_OUT, {modes[i], modes[i], 4'h0});
      wr(ADDR_CLK_FORCE, 8'hC0);
      repeat (2) @(posedge pclk);
      chk(cmp_b_pin, {pins[i], 1'b1});
      chk(cmp_a_pin, {pins[i], 1'b1});
    end
    rd(ADDR_FLAGS); chk(rdat, 32'h0000_0000);
    wr(ADDR_PIN_CTRL, 8'h00);
    repeat (2) @(posedge pclk);
    chk(cmp_b_pin.oe, 1'b0);
    // A force strobe in fast PWM must leave the pin alone.
    wr(ADDR_PIN_CTRL, 8'h03);
    wr(ADDR_WAVE_OUT, 8'hF3);
    wr(ADDR_CLK_FORCE, 8'hC0);
    repeat (2) @(posedge pclk);
    chk(cmp_b_pin.pin, 1'b0);
    // Later writes in a PWM mode keep both force bits at zero.
    wr(ADDR_CLK_FORCE, 8'h00);
    repeat (2) @(posedge pclk);
    chk(cmp_b_pin.pin, 1'b0);
    results();
  end
endmodule

`default_nettype wire
